// file: core/ubrg_divider.sv
// reloadable pulse divider: one output pulse per divisor source pulses
module ubrg_divider #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         run,
    input  wire logic         src_pulse,
    input  wire logic [W-1:0] divisor,
    output logic              pulse
);

    logic [W-1:0] cnt;
    logic [W-1:0] last;

    assign last = divisor - W'(1);

    // counts source pulses, wraps at divisor-1 and emits one pulse [R16]
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt   <= '0;
            pulse <= 1'b0;
        end
        else if (!run)
        begin
            pulse <= 1'b0; // state kept as is while gated [R10]
        end
        else if (divisor == '0)
        begin
            cnt   <= '0;
            pulse <= 1'b0; // no clock at all [R3]
        end
        else if (divisor == W'(1))
        begin
            cnt   <= '0;
            pulse <= src_pulse; // divider bypassed [R4]
        end
        else if (src_pulse)
        begin
            // a lowered divisor below cnt wraps at once, never runs away
            if (cnt >= last)
            begin
                cnt   <= '0;
                pulse <= 1'b1; // [R2]
            end
            else
            begin
                cnt   <= cnt + W'(1);
                pulse <= 1'b0;
            end
        end
        else
        begin
            pulse <= 1'b0;
        end
    end

    AST_FREEZE_CNT: assert property (@(posedge clk) disable iff (!nrst)
        !run |=> $stable(cnt)) // [R10]
        else $error("divider count moved while gated");

endmodule : ubrg_divider

// file: core/ubrg_top.sv
// baud rate generator with modem pins, interrupt and axi4-lite registers
// Notes on behaviour
// R1 - source is master clock, master clock divided by eight, or serial clock
// R2 - a 16-bit divisor register divides the selected source
// R3 - divisor zero produces no baud clock
// R4 - divisor one passes the selected source straight through
// R5 - external serial clock highs and lows last over one master period
// R6 - external serial clock runs at least 4.5 times slower than master
// R7 - async: divided clock is the sampling clock, 8x or 16x baud
// R8 - async baud equals source over 8, over (2-over), over divisor
// R9 - without modem pins their control and status bits have no effect
// R10 - with the clock gated every state holds and resumes unchanged; here only the divider counts hold, modem sampling, status and IRQ keep running
// R11 - configuration writes are taken even while the clock is gated
// R12 - interrupt controller should treat the interrupt as level sensitive
// R13 - software keeps relative baud error at or below five percent
// R14 - sync: baud clock is selected clock over divisor, no oversampling
// R15 - sync with serial clock source: pin gives bit timing, divisor unused
// R16 - divider reloads and pulses once per period; serial clock synchronised
// R17 - rts and dtr driven active low; ri, dsr, dcd, cts active low
module ubrg_top #(
    parameter logic [15:0] PRESCALE  = ubrg_pkg::PRE_DIV,
    parameter bit          HAS_MODEM = 1'b1
) (
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        PERIPH_CLK_ON,
    input  wire logic        SCK_IN,
    input  wire logic        RI_N,
    input  wire logic        DSR_N,
    input  wire logic        DCD_N,
    input  wire logic        CTS_N,
    output logic             RTS_N,
    output logic             DTR_N,
    output logic             SAMPLE_TICK,
    output logic             BAUD_TICK,
    output logic             IRQ,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    ubrg_pkg::ubrg_mode_t  mode;
    ubrg_pkg::ubrg_modem_t modem_now;
    ubrg_pkg::ubrg_modem_t modem_prev;
    logic [15:0]           divisor;
    logic [15:0]           ovs_div;
    logic [1:0]            mctrl;
    logic [1:0]            status;
    logic [1:0]            mask;
    logic [1:0]            events;
    logic [1:0]            rd_clear;
    logic [7:0]            wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    logic                  aw_got;
    logic                  w_got;
    logic                  wr_fire;
    logic                  rd_fire;
    logic [31:0]           rd_value;
    logic                  rd_ok;
    logic                  sck_meta;
    logic                  sck_sync;
    logic                  sck_prev;
    logic                  sck_rise;
    logic                  pre_pulse;
    logic                  src_pulse;
    logic                  samp_pulse;
    logic                  ovs_pulse;
    logic                  next_baud;
    logic                  cfg_dirty;
    logic [4:0]            samp_cnt;

    // write channel: address and data taken in either order
    assign wr_fire = aw_got && w_got && !S_AXI_BVALID;
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= ubrg_pkg::RESP_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                wr_addr       <= S_AXI_AWADDR;
                aw_got        <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                wr_data      <= S_AXI_WDATA;
                wr_strb      <= S_AXI_WSTRB;
                w_got        <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (wr_addr[7:2] <= ubrg_pkg::OFF_MASK[7:2])
                             || (wr_addr[7:2] == ubrg_pkg::OFF_MCTRL[7:2])
                              ? ubrg_pkg::RESP_OKAY : ubrg_pkg::RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // configuration is on the bus clock, never behind the gate [R11]
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            mode    <= '0;
            divisor <= ubrg_pkg::DIV_RESET;
            mask    <= '0;
            mctrl   <= '0;
        end
        else if (wr_fire)
        begin
            unique case (wr_addr[7:2])
                ubrg_pkg::OFF_MODE[7:2]:
                    if (wr_strb[0])
                    begin
                        mode.src  <= wr_data[ubrg_pkg::MODE_SRC_LSB +: 2];
                        mode.sync <= wr_data[ubrg_pkg::MODE_SYNC];
                        mode.over <= wr_data[ubrg_pkg::MODE_OVER];
                    end
                ubrg_pkg::OFF_DIV[7:2]:
                begin
                    if (wr_strb[0])
                        divisor[7:0] <= wr_data[7:0]; // [R2]
                    if (wr_strb[1])
                        divisor[15:8] <= wr_data[15:8];
                end
                ubrg_pkg::OFF_MASK[7:2]:
                    if (wr_strb[0])
                        mask <= wr_data[ubrg_pkg::ST_W-1:0];
                ubrg_pkg::OFF_MCTRL[7:2]:
                    if (wr_strb[0])
                        mctrl <= wr_data[1:0];
                default:
                    mctrl <= mctrl;
            endcase
        end
    end

    // read mux; modem status reads zero on an instance without pins [R9]
    always_comb
    begin
        rd_value = '0;
        rd_ok    = 1'b1;
        unique case (S_AXI_ARADDR[7:2])
            ubrg_pkg::OFF_MODE[7:2]:
            begin
                rd_value[ubrg_pkg::MODE_SRC_LSB +: 2] = mode.src;
                rd_value[ubrg_pkg::MODE_SYNC]         = mode.sync;
                rd_value[ubrg_pkg::MODE_OVER]         = mode.over;
            end
            ubrg_pkg::OFF_DIV[7:2]:    rd_value[15:0] = divisor;
            ubrg_pkg::OFF_STATUS[7:2]: rd_value[1:0]  = status;
            ubrg_pkg::OFF_MASK[7:2]:   rd_value[1:0]  = mask;
            ubrg_pkg::OFF_MCTRL[7:2]:  rd_value[1:0]  = mctrl;
            ubrg_pkg::OFF_MSTAT[7:2]:
                rd_value[3:0] = HAS_MODEM ? modem_now : 4'h0; // [R9]
            default:                   rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= ubrg_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_value;
            S_AXI_RRESP   <= rd_ok ? ubrg_pkg::RESP_OKAY
                                   : ubrg_pkg::RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // modem pins are active low; logic works with asserted-high copies
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            modem_now  <= '0;
            modem_prev <= '0;
        end
        else
        begin
            modem_now  <= {!RI_N, !DCD_N, !DSR_N, !CTS_N}; // [R17]
            modem_prev <= modem_now;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            RTS_N <= 1'b1;
            DTR_N <= 1'b1;
        end
        else
        begin
            // missing pins stay inactive whatever software writes [R9]
            RTS_N <= !(HAS_MODEM && mctrl[ubrg_pkg::MC_RTS]); // [R17]
            DTR_N <= !(HAS_MODEM && mctrl[ubrg_pkg::MC_DTR]); // [R17]
        end
    end

    // serial clock pin synchroniser; relies on slow, wide pin levels [R5] [R6]
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
        end
        else
        begin
            sck_meta <= SCK_IN; // [R16]
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
        end
    end

    assign sck_rise = sck_sync && !sck_prev && PERIPH_CLK_ON;

    // fixed prescaler for the divided master clock source
    ubrg_divider #(.W(16)) u_pre (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .run       (PERIPH_CLK_ON),
        .src_pulse (PERIPH_CLK_ON),
        .divisor   (PRESCALE),
        .pulse     (pre_pulse)
    );

    // source select; the unused code 2 behaves as the master clock
    always_comb
    begin
        unique case (mode.src)
            ubrg_pkg::SRC_MCK_DIV: src_pulse = pre_pulse; // [R1]
            ubrg_pkg::SRC_SCK:     src_pulse = sck_rise;  // [R1]
            default:               src_pulse = PERIPH_CLK_ON; // [R1]
        endcase
    end

    ubrg_divider #(.W(16)) u_div (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .run       (PERIPH_CLK_ON),
        .src_pulse (src_pulse),
        .divisor   (divisor),
        .pulse     (samp_pulse)
    );

    // oversampling stage: by 8 with over set, else by 16 [R7] [R8]
    assign ovs_div = mode.over ? ubrg_pkg::OVS_BY_8 : ubrg_pkg::OVS_BY_16;

    ubrg_divider #(.W(16)) u_ovs (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .run       (PERIPH_CLK_ON),
        .src_pulse (samp_pulse),
        .divisor   (ovs_div),
        .pulse     (ovs_pulse)
    );

    // sync mode skips oversampling; external clock skips the divisor too
    always_comb
    begin
        if (!mode.sync)
            next_baud = ovs_pulse; // [R8]
        else if (mode.src == ubrg_pkg::SRC_SCK)
            next_baud = sck_rise; // [R15]
        else
            next_baud = samp_pulse; // [R14]
    end

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            SAMPLE_TICK <= 1'b0;
            BAUD_TICK   <= 1'b0;
        end
        else
        begin
            SAMPLE_TICK <= samp_pulse; // [R7]
            BAUD_TICK   <= next_baud;
        end
    end

    // sticky events; a new event wins over the read that clears it
    assign events[ubrg_pkg::ST_BAUD]  = BAUD_TICK;
    assign events[ubrg_pkg::ST_MODEM] = HAS_MODEM
                                     && (modem_now != modem_prev); // [R9]
    assign rd_clear = (rd_fire
        && S_AXI_ARADDR[7:2] == ubrg_pkg::OFF_STATUS[7:2]) ? 2'h3 : 2'h0;

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            status <= '0;
            IRQ    <= 1'b0;
        end
        else
        begin
            status <= (status & ~rd_clear) | events;
            // level output, stays high until the status is read [R12]
            IRQ    <= |(((status & ~rd_clear) | events) & mask);
        end
    end

    // helper for the ratio check: sample ticks per baud tick
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            samp_cnt  <= '0;
            cfg_dirty <= 1'b1;
        end
        else
        begin
            if (BAUD_TICK)
                samp_cnt <= '0;
            else if (SAMPLE_TICK)
                samp_cnt <= samp_cnt + 5'h01;
            if (wr_fire && wr_addr[7:3] == 5'h00)
                cfg_dirty <= 1'b1;
            else if (BAUD_TICK)
                cfg_dirty <= 1'b0;
        end
    end

    AST_SRC_PRESCALE: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (mode.src == ubrg_pkg::SRC_MCK_DIV && divisor == 16'h0001
         && PERIPH_CLK_ON)[*8] ##0 $past(SAMPLE_TICK, 7)
        |-> !SAMPLE_TICK) // [R1]
        else $error("prescaled source period is not eight");

    AST_ZERO_DIV: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (divisor == 16'h0000)[*4] |-> !SAMPLE_TICK) // [R3]
        else $error("sample tick with divisor zero");

    AST_BYPASS: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (mode.src == ubrg_pkg::SRC_MCK && divisor == 16'h0001
         && PERIPH_CLK_ON)[*4] |-> SAMPLE_TICK) // [R4]
        else $error("divisor one does not pass the source");

    AST_ASYNC_RATIO: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        BAUD_TICK && !mode.sync && !cfg_dirty
        |-> samp_cnt + 5'(SAMPLE_TICK) == (mode.over ? 5'd8 : 5'd16)) // [R8]
        else $error("sample ticks per baud tick wrong");

    AST_SYNC_DIV: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        mode.sync && mode.src != ubrg_pkg::SRC_SCK ##1
        mode.sync && mode.src != ubrg_pkg::SRC_SCK
        |-> BAUD_TICK == SAMPLE_TICK) // [R14]
        else $error("sync baud tick differs from divided clock");

    AST_SYNC_EXT: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        mode.sync && mode.src == ubrg_pkg::SRC_SCK && sck_rise
        |=> BAUD_TICK) // [R15]
        else $error("serial clock edge gave no baud tick");

    AST_GATED: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (!PERIPH_CLK_ON)[*3] |-> !SAMPLE_TICK && !BAUD_TICK) // [R10]
        else $error("ticks while the clock is gated");

    AST_CFG_WRITE: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_fire && wr_addr[7:2] == ubrg_pkg::OFF_DIV[7:2]
        && wr_strb == 4'hF |=> divisor == $past(wr_data[15:0])) // [R11]
        else $error("divisor write lost");

    AST_NO_MODEM: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !HAS_MODEM |-> RTS_N && DTR_N && !status[ubrg_pkg::ST_MODEM]) // [R9]
        else $error("absent modem pins show effect");

    AST_RTS_LOW: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        HAS_MODEM && mctrl[ubrg_pkg::MC_RTS] |=> !RTS_N) // [R17]
        else $error("request to send not driven low");

endmodule : ubrg_top

// file: pkg/ubrg_pkg.sv
// shared constants and carrier types of the baud rate generator
package ubrg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIV_W  = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DIV    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_MCTRL  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MSTAT  = 8'h14;

    // mode register fields
    localparam int MODE_SRC_LSB = 0;
    localparam int MODE_SYNC    = 4;
    localparam int MODE_OVER    = 5;

    // source select encodings
    localparam logic [1:0] SRC_MCK     = 2'h0;
    localparam logic [1:0] SRC_MCK_DIV = 2'h1;
    localparam logic [1:0] SRC_SCK     = 2'h3;

    // status and mask bits
    localparam int ST_BAUD  = 0;
    localparam int ST_MODEM = 1;
    localparam int ST_W     = 2;

    // modem control bits, modem status bits
    localparam int MC_RTS = 0;
    localparam int MC_DTR = 1;
    localparam int MS_CTS = 0;
    localparam int MS_DSR = 1;
    localparam int MS_DCD = 2;
    localparam int MS_RI  = 3;

    // reset values and fixed ratios
    localparam logic [DIV_W-1:0] DIV_RESET  = 16'h0000;
    localparam logic [DIV_W-1:0] PRE_DIV    = 16'h0008;
    localparam logic [DIV_W-1:0] OVS_BY_16  = 16'h0010;
    localparam logic [DIV_W-1:0] OVS_BY_8   = 16'h0008;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       over;
        logic       sync;
        logic [1:0] src;
    } ubrg_mode_t;

    typedef struct packed {
        logic ri;
        logic dcd;
        logic dsr;
        logic cts;
    } ubrg_modem_t;

endpackage : ubrg_pkg

// file: test/tb_usart_baud_rate_generator.sv
// self-checking bench of the baud rate generator over its register bus
module tb_usart_baud_rate_generator;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 20000;
    logic        clk, nrst, gate, sck_run, sck, rts_n, dtr_n;
    logic        stick, btick, irq;
    logic [1:0]  bare_n;
    logic [3:0]  pins_req, pins_n;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [7:0]  c_mode [9] = '{8'h20, 8'h00, 8'h21, 8'h21, 8'h10,
                               8'h13, 8'h23, 8'h22, 8'h20};
    int          c_div [9] = '{1, 3, 2, 1, 5, 0, 1, 1, 0};
    int          c_len [9] = '{64, 96, 256, 128, 50, 64, 128, 64, 64};
    int          c_smp [9] = '{64, 32, 16, 16, 10, 0, 16, 64, 0};
    int          c_bd  [9] = '{8, 2, 2, 2, 10, 8, 2, 8, 0};

    ubrg_top dut (
        .CLK_SYS(clk), .NRST(nrst), .PERIPH_CLK_ON(gate), .SCK_IN(sck),
        .RI_N(pins_n[3]), .DCD_N(pins_n[2]), .DSR_N(pins_n[1]),
        .CTS_N(pins_n[0]), .RTS_N(rts_n), .DTR_N(dtr_n),
        .SAMPLE_TICK(stick), .BAUD_TICK(btick), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    // instance without modem pins: control and status must stay inert
    ubrg_top #(.HAS_MODEM(1'b0)) dut_bare (
        .CLK_SYS(clk), .NRST(nrst), .PERIPH_CLK_ON(gate), .SCK_IN(sck),
        .RI_N(pins_n[3]), .DCD_N(pins_n[2]), .DSR_N(pins_n[1]),
        .CTS_N(pins_n[0]), .RTS_N(bare_n[0]), .DTR_N(bare_n[1]),
        .SAMPLE_TICK(), .BAUD_TICK(), .IRQ(),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
        .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(), .S_AXI_RDATA(), .S_AXI_RRESP(),
        .S_AXI_RVALID(), .S_AXI_RREADY(rready)
    );

    ubrg_remote remote (
        .clk(clk), .run(sck_run), .lines_req(pins_req), .sck(sck),
        .lines_n(pins_n)
    );

    always #2.5 clk = ~clk;

    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", d, rdata);
        chk("rresp", {30'h0, r}, {30'h0, rresp});
    endtask : axi_rd

    // window lengths are whole periods, so counts do not depend on phase
    task automatic measure(input int n, input int es, input int eb);
        int s;
        int b;
        s = 0;
        b = 0;
        repeat (n)
        begin
            @(posedge clk);
            s += int'(stick === 1'b1);
            b += int'(btick === 1'b1);
        end
        if (es >= 0) chk("sample_ticks", 32'(es), 32'(s));
        chk("baud_ticks", 32'(eb), 32'(b));
    endtask : measure

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        gate = 1'b1;
        sck_run = 1'b0;
        pins_req = 4'hF;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++)
            axi_rd(8'(4 * i), 32'h0, ubrg_pkg::RESP_OKAY);
        chk("modem_out", 32'h3, {30'h0, dtr_n, rts_n});
        for (int i = 0; i < 9; i++)
        begin
            sck_run <= (c_mode[i][1:0] == 2'h3);
            axi_wr(ubrg_pkg::OFF_DIV, 32'(c_div[i]), ubrg_pkg::RESP_OKAY);
            axi_wr(ubrg_pkg::OFF_MODE, {24'h0, c_mode[i]},
                   ubrg_pkg::RESP_OKAY);
            repeat (300) @(posedge clk);
            measure(c_len[i], c_smp[i], c_bd[i]);
        end
        axi_wr(ubrg_pkg::OFF_DIV, 32'h1, ubrg_pkg::RESP_OKAY);
        @(posedge clk);
        gate <= 1'b0;
        repeat (3) @(posedge clk);
        measure(40, 0, 0);
        axi_wr(ubrg_pkg::OFF_DIV, 32'h5, ubrg_pkg::RESP_OKAY);
        axi_rd(ubrg_pkg::OFF_DIV, 32'h5, ubrg_pkg::RESP_OKAY);
        gate <= 1'b1;
        repeat (300) @(posedge clk);
        measure(80, 16, 2);
        repeat (50) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        axi_wr(ubrg_pkg::OFF_MASK, 32'h1, ubrg_pkg::RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        axi_wr(ubrg_pkg::OFF_DIV, 32'h0, ubrg_pkg::RESP_OKAY);
        repeat (20) @(posedge clk);
        axi_rd(ubrg_pkg::OFF_STATUS, 32'h1, ubrg_pkg::RESP_OKAY);
        axi_rd(ubrg_pkg::OFF_STATUS, 32'h0, ubrg_pkg::RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        pins_req <= 4'hA;
        repeat (10) @(posedge clk);
        axi_rd(ubrg_pkg::OFF_STATUS, 32'h2, ubrg_pkg::RESP_OKAY);
        axi_rd(ubrg_pkg::OFF_MSTAT, 32'h5, ubrg_pkg::RESP_OKAY);
        axi_wr(ubrg_pkg::OFF_MCTRL, 32'h3, ubrg_pkg::RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("modem_out", 32'h0, {30'h0, dtr_n, rts_n});
        chk("bare_modem", 32'h3, {30'h0, bare_n});
        axi_wr(ubrg_pkg::OFF_MCTRL, 32'h1, ubrg_pkg::RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("modem_out", 32'h2, {30'h0, dtr_n, rts_n});
        axi_wr(ubrg_pkg::OFF_MSTAT, 32'h0, ubrg_pkg::RESP_SLVERR);
        axi_wr(ubrg_pkg::OFF_STATUS, 32'h3, ubrg_pkg::RESP_OKAY);
        axi_rd(ubrg_pkg::OFF_STATUS, 32'h0, ubrg_pkg::RESP_OKAY);
        axi_wr(8'h20, 32'h5, ubrg_pkg::RESP_SLVERR);
        axi_rd(8'h20, 32'h0, ubrg_pkg::RESP_SLVERR);
        results();
    end
endmodule : tb_usart_baud_rate_generator

// file: test/ubrg_remote.sv
// far-side model: serial clock source and modem status lines
module ubrg_remote #(
    parameter int HALF = 4
) (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [3:0] lines_req,
    output logic            sck,
    output logic [3:0]      lines_n
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;

    initial
    begin
        sck = 1'b0;
        cnt = 0;
        lines_n = 4'hF;
    end

    // clock rests low outside frames so no stray edge reaches the divider
    always @(posedge clk)
    begin
        if (!run)
        begin
            cnt <= 0;
            sck <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            sck <= ~sck;
        end
        else
            cnt <= cnt + 1;
    end

    // pins are active low: a request bit of 0 asserts the line
    always @(posedge clk)
        lines_n <= lines_req;
endmodule : ubrg_remote
